// file: core/ssu_pkg.sv
// Shared constants and carrier types for the set and skip execution unit
package ssu_pkg;
  // Opcodes of the handled instructions
  localparam logic [9:0] OP_BANK_SET   = 10'h041;
  localparam logic [9:0] OP_BANK_CLR   = 10'h040;
  localparam logic [9:0] OP_CARRY_SET  = 10'h007;
  localparam logic [9:0] OP_PORTC_SET  = 10'h28d;
  localparam logic [9:0] OP_PORTD_SET  = 10'h015;
  localparam logic [9:0] OP_IMM_CMP    = 10'h025;
  localparam logic [9:0] OP_MEM_CMP    = 10'h026;
  localparam logic [9:0] OP_EXT0_FLAG  = 10'h038;
  localparam logic [9:0] OP_EXT1_FLAG  = 10'h039;
  localparam logic [9:0] OP_EXT0_PIN   = 10'h03a;
  localparam logic [9:0] OP_EXT1_PIN   = 10'h03b;
  localparam logic [9:0] OP_PWRDN_TEST = 10'h003;
  localparam logic [9:0] OP_CONV_TEST  = 10'h287;
  localparam logic [9:0] OP_SER_TEST   = 10'h288;
  localparam logic [9:0] OP_TMR1_TEST  = 10'h280;
  localparam logic [9:0] OP_TMR2_TEST  = 10'h281;
  localparam logic [9:0] OP_TMR3_TEST  = 10'h282;
  // Table reference: upper four bits select, low six carry the page
  localparam logic [3:0] TBL_REF_HI    = 4'h2;
  // Enable bits in the two interrupt control registers, and POL_BIT, the pin polarity bit of the two pin control registers
  localparam int EXT0_EN_BIT = 0;
  localparam int EXT1_EN_BIT = 1;
  localparam int TMR1_EN_BIT = 2;
  localparam int TMR2_EN_BIT = 3;
  localparam int TMR3_EN_BIT = 0;
  localparam int CONV_EN_BIT = 2;
  localparam int SER_EN_BIT  = 3;
  localparam int POL_BIT     = 2;
  // Table page limits and the last port D bit
  localparam logic [6:0] UPPER_BASE = 7'h40;
  localparam logic [6:0] LAST_SMALL = 7'h3f;
  localparam logic [6:0] LAST_MID   = 7'h5f;
  localparam logic [6:0] LAST_FULL  = 7'h7f;
  localparam logic [3:0] PORTD_LAST = 4'h9;
  // Register map (byte addresses) and interrupt and pin control register reset value
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_ICTL1  = 8'h04;
  localparam logic [7:0] ADDR_ICTL2  = 8'h08;
  localparam logic [7:0] ADDR_INCTL1 = 8'h0c;
  localparam logic [7:0] ADDR_INCTL2 = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_PORTD  = 8'h18;
  localparam logic [3:0] CTL_RST     = 4'h0;
  // Status register fields
  localparam int ST_BANK     = 0;
  localparam int ST_PORTC    = 1;
  localparam int ST_PWRDN    = 2;
  localparam int ST_FLAG_LSB = 4;
  localparam int ST_PAGE_ERR = 11;
  localparam int NUM_FLAGS   = 7;

  typedef enum logic [1:0] {
    VAR_SMALL = 2'b00,
    VAR_MID   = 2'b01,
    VAR_FULL  = 2'b10
  } ssu_variant_t;

  typedef enum logic [1:0] {
    SEQ_RUN   = 2'b00,
    SEQ_IMM   = 2'b01,
    SEQ_SKIP  = 2'b10,
    SEQ_SKIP2 = 2'b11
  } ssu_seq_t;

  // Bit 0 is ext0, bit 6 is timer 3
  typedef struct packed {
    logic t3, t2, t1, ser, conv, ext1, ext0;
  } ssu_req_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } ssu_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } ssu_apb_rsp_t;

  typedef struct packed {
    logic       valid;
    logic [9:0] word;
    logic [3:0] acc;
    logic [3:0] mem;
    logic [3:0] y;
  } ssu_instr_t;
endpackage

// file: core/ssu_sync.sv
// Two flip-flop synchroniser for one pin level
`timescale 1ns/1ns
module ssu_sync (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rstn,
  // Level in and out
  input  wire logic din,
  output      logic dout
);
  typedef struct packed {
    logic s1;
    logic s2;
  } ssu_sync_st_t;
  ssu_sync_st_t s_r, s_nxt;

  always_comb begin
    s_nxt    = s_r;
    s_nxt.s1 = din;
    s_nxt.s2 = s_r.s1;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign dout = s_r.s2;
endmodule

// file: core/ssu_flag_test.sv
// Enable-gated request flag test: skip and clear decision
`timescale 1ns/1ns
module ssu_flag_test (
  // Decode and state
  input  wire logic sel,
  input  wire logic en_bit,
  input  wire logic flag,
  // Decision
  output      logic skip,
  output      logic clr
);
  // An enabled source is serviced by interrupt, so the test is a no-op
  always_comb begin
    skip = sel && !en_bit && flag;
    clr  = sel && !en_bit && flag;
  end
endmodule

// file: core/ssu_exec.sv
// Set, compare-and-skip and flag-test-and-skip execution unit
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ns
module ssu_exec (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rstn,
  // Register bus
  input  wire ssu_pkg::ssu_apb_req_t  apb_req,
  output      ssu_pkg::ssu_apb_rsp_t  apb_rsp,
  // Instruction stream
  input  wire ssu_pkg::ssu_instr_t    instr,
  input  wire logic                   pwrdn_flag,
  input  wire ssu_pkg::ssu_req_t      req_set,
  // Pins
  input  wire logic                   ext0_pin,
  input  wire logic                   ext1_pin,
  // Sequencing
  output      logic                   pc_inc,
  output      logic                   word_skipped,
  // Results
  output      logic                   table_bank_bit,
  output      logic [6:0]             tbl_page,
  output      logic                   tbl_page_vld,
  output      logic                   carry_set,
  output      logic                   port_c,
  output      logic [9:0]             port_d,
  output      ssu_pkg::ssu_req_t      req_flags
);
  import ssu_pkg::*;

  typedef struct packed {
    ssu_seq_t     seq;
    ssu_variant_t variant;
    logic [3:0]   ictl1;
    logic [3:0]   ictl2;
    logic [3:0]   inctl1;
    logic [3:0]   inctl2;
    ssu_req_t     flags;
    logic         bank;
    logic [6:0]   page;
    logic         page_vld;
    logic         page_err;
    logic         carry_set;
    logic         portc;
    logic [9:0]   portd;
    logic         pc_inc;
    logic         skipped;
    ssu_apb_rsp_t rsp;
  } ssu_state_t;

  ssu_state_t s_r, s_nxt;

  logic                 pin0_s;
  logic                 pin1_s;
  logic                 exec;
  logic [9:0]           w;
  logic [NUM_FLAGS-1:0] ft_sel;
  logic [NUM_FLAGS-1:0] ft_en;
  logic [NUM_FLAGS-1:0] ft_skip;
  logic [NUM_FLAGS-1:0] ft_clr;
  logic                 pin0_skip;
  logic                 pin1_skip;
  logic                 pwr_skip;
  logic                 mem_skip;
  logic                 skip_any;
  logic [6:0]           last_page;
  logic [6:0]           ref_page;

  ssu_sync u_sync0 (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .din     (ext0_pin),
    .dout    (pin0_s)
  );

  ssu_sync u_sync1 (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .din     (ext1_pin),
    .dout    (pin1_s)
  );

  // A word is an opcode only outside an immediate fetch or a skip
  assign exec = instr.valid && (s_r.seq == SEQ_RUN);
  assign w    = instr.word;

  assign ft_sel[0] = exec && (w == OP_EXT0_FLAG);
  assign ft_sel[1] = exec && (w == OP_EXT1_FLAG);
  assign ft_sel[2] = exec && (w == OP_CONV_TEST);
  assign ft_sel[3] = exec && (w == OP_SER_TEST);
  assign ft_sel[4] = exec && (w == OP_TMR1_TEST);
  assign ft_sel[5] = exec && (w == OP_TMR2_TEST);
  assign ft_sel[6] = exec && (w == OP_TMR3_TEST);
  assign ft_en[0]  = s_r.ictl1[EXT0_EN_BIT];
  assign ft_en[1]  = s_r.ictl1[EXT1_EN_BIT];
  assign ft_en[2]  = s_r.ictl2[CONV_EN_BIT];
  assign ft_en[3]  = s_r.ictl2[SER_EN_BIT];
  assign ft_en[4]  = s_r.ictl1[TMR1_EN_BIT];
  assign ft_en[5]  = s_r.ictl1[TMR2_EN_BIT];
  assign ft_en[6]  = s_r.ictl2[TMR3_EN_BIT];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_FLAGS; gi++) begin : g_ft
      ssu_flag_test u_ft (
        .sel    (ft_sel[gi]),
        .en_bit (ft_en[gi]),
        .flag   (s_r.flags[gi]),
        .skip   (ft_skip[gi]),
        .clr    (ft_clr[gi])
      );
    end
  endgenerate

  // Polarity bit equal to the pin level means skip
  assign pin0_skip = exec && (w == OP_EXT0_PIN) && (pin0_s == s_r.inctl1[POL_BIT]);
  assign pin1_skip = exec && (w == OP_EXT1_PIN) && (pin1_s == s_r.inctl2[POL_BIT]);
  assign pwr_skip  = exec && (w == OP_PWRDN_TEST) && pwrdn_flag;
  assign mem_skip  = exec && (w == OP_MEM_CMP) && (instr.acc == instr.mem);
  assign skip_any  = (|ft_skip) || pin0_skip || pin1_skip || pwr_skip || mem_skip;

  always_comb begin
    case (s_r.variant)
      VAR_SMALL: last_page = LAST_SMALL;
      VAR_MID:   last_page = LAST_MID;
      default:   last_page = LAST_FULL;
    endcase
    ref_page = {1'b0, w[5:0]};
    if (s_r.bank) begin
      ref_page = UPPER_BASE | {1'b0, w[5:0]};
    end
  end

  always_comb begin
    s_nxt           = s_r;
    s_nxt.pc_inc    = 1'b0;
    s_nxt.skipped   = 1'b0;
    s_nxt.carry_set = 1'b0;
    s_nxt.page_vld  = 1'b0;
    // A new request in the clearing cycle survives
    s_nxt.flags     = (s_r.flags & ~ft_clr) | req_set;
    // Bus writes come first, so a page error raised in the same cycle beats its clear
    if (apb_req.psel && apb_req.penable && s_r.rsp.pready && apb_req.pwrite) begin
      case (apb_req.paddr)
        ADDR_CTRL:   s_nxt.variant = ssu_variant_t'(apb_req.pwdata[1:0]);
        ADDR_ICTL1:  s_nxt.ictl1   = apb_req.pwdata[3:0];
        ADDR_ICTL2:  s_nxt.ictl2   = apb_req.pwdata[3:0];
        ADDR_INCTL1: s_nxt.inctl1  = apb_req.pwdata[3:0];
        ADDR_INCTL2: s_nxt.inctl2  = apb_req.pwdata[3:0];
        ADDR_STATUS: begin
          if (apb_req.pwdata[ST_PAGE_ERR]) begin
            s_nxt.page_err = 1'b0;
          end
        end
        default: s_nxt.page_err = s_nxt.page_err;
      endcase
    end
    case (s_r.seq)
      SEQ_RUN: begin
        if (instr.valid) begin
          s_nxt.pc_inc = 1'b1;
          if (w == OP_IMM_CMP) begin
            s_nxt.seq = SEQ_IMM;
          end else if (skip_any) begin
            s_nxt.seq = SEQ_SKIP;
          end
          if ((w == OP_BANK_SET) && (s_r.variant != VAR_SMALL)) begin
            s_nxt.bank = 1'b1;
          end
          if (w == OP_BANK_CLR) begin
            s_nxt.bank = 1'b0;
          end
          if (w == OP_CARRY_SET) begin
            s_nxt.carry_set = 1'b1;
          end
          if (w == OP_PORTC_SET) begin
            s_nxt.portc = 1'b1;
          end
          // Pointer values past the last port bit are ignored
          if ((w == OP_PORTD_SET) && (instr.y <= PORTD_LAST)) begin
            s_nxt.portd[instr.y] = 1'b1;
          end
          if (w[9:6] == TBL_REF_HI) begin
            s_nxt.page_vld = 1'b1;
            s_nxt.page     = ref_page;
            if (ref_page > last_page) begin
              s_nxt.page_err = 1'b1;
            end
          end
        end
      end
      SEQ_IMM: begin
        if (instr.valid) begin
          s_nxt.pc_inc = 1'b1;
          s_nxt.seq    = (instr.acc == w[3:0]) ? SEQ_SKIP : SEQ_RUN;
        end
      end
      SEQ_SKIP: begin
        if (instr.valid) begin
          // A skipped two-word compare must lose its immediate word too
          s_nxt.pc_inc  = 1'b1;
          s_nxt.skipped = 1'b1;
          s_nxt.seq     = (w == OP_IMM_CMP) ? SEQ_SKIP2 : SEQ_RUN;
        end
      end
      SEQ_SKIP2: begin
        if (instr.valid) begin
          s_nxt.pc_inc  = 1'b1;
          s_nxt.skipped = 1'b1;
          s_nxt.seq     = SEQ_RUN;
        end
      end
      default: s_nxt.seq = SEQ_RUN;
    endcase
    // Register bus: decode in setup, answer with one wait-free access cycle
    s_nxt.rsp.pready  = 1'b0;
    s_nxt.rsp.pslverr = 1'b0;
    if (apb_req.psel && !apb_req.penable) begin
      s_nxt.rsp.pready = 1'b1;
      s_nxt.rsp.prdata = '0;
      case (apb_req.paddr)
        ADDR_CTRL:   s_nxt.rsp.prdata[1:0] = s_r.variant;
        ADDR_ICTL1:  s_nxt.rsp.prdata[3:0] = s_r.ictl1;
        ADDR_ICTL2:  s_nxt.rsp.prdata[3:0] = s_r.ictl2;
        ADDR_INCTL1: s_nxt.rsp.prdata[3:0] = s_r.inctl1;
        ADDR_INCTL2: s_nxt.rsp.prdata[3:0] = s_r.inctl2;
        ADDR_STATUS: begin
          s_nxt.rsp.prdata[ST_BANK]  = s_r.bank;
          s_nxt.rsp.prdata[ST_PORTC] = s_r.portc;
          s_nxt.rsp.prdata[ST_PWRDN] = pwrdn_flag;
          s_nxt.rsp.prdata[ST_FLAG_LSB +: NUM_FLAGS] = s_r.flags;
          s_nxt.rsp.prdata[ST_PAGE_ERR] = s_r.page_err;
        end
        ADDR_PORTD:  s_nxt.rsp.prdata[9:0] = s_r.portd;
        default:     s_nxt.rsp.pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_r         <= '0;
      s_r.seq     <= SEQ_RUN;
      s_r.variant <= VAR_FULL;
      s_r.ictl1   <= CTL_RST;
      s_r.ictl2   <= CTL_RST;
      s_r.inctl1  <= CTL_RST;
      s_r.inctl2  <= CTL_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign apb_rsp        = s_r.rsp;
  assign pc_inc         = s_r.pc_inc;
  assign word_skipped   = s_r.skipped;
  assign table_bank_bit = s_r.bank;
  assign tbl_page       = s_r.page;
  assign tbl_page_vld   = s_r.page_vld;
  assign carry_set      = s_r.carry_set;
  assign port_c         = s_r.portc;
  assign port_d         = s_r.portd;
  assign req_flags      = s_r.flags;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  property p_bank_set;
    exec && (w == OP_BANK_SET) && (s_r.variant != VAR_SMALL) |=> table_bank_bit ##1 1'b1;
  endproperty
  a_bank_set: assert property (p_bank_set) else $error("bank set missed");

  property p_bank_small;
    exec && (w == OP_BANK_SET) && (s_r.variant == VAR_SMALL) && !table_bank_bit
      |=> !table_bank_bit;
  endproperty
  a_bank_small: assert property (p_bank_small) else $error("small variant set bank");

  property p_carry;
    carry_set |-> $past(exec) && ($past(w) == OP_CARRY_SET);
  endproperty
  a_carry: assert property (p_carry) else $error("carry set without cause");

  property p_portd;
    exec && (w == OP_PORTD_SET) && (instr.y <= PORTD_LAST) |=> port_d[$past(instr.y)];
  endproperty
  a_portd: assert property (p_portd) else $error("port D bit not set");

  property p_imm;
    exec && (w == OP_IMM_CMP) ##1 instr.valid && (instr.acc == w[3:0])
      |=> (s_r.seq == SEQ_SKIP) && pc_inc && !word_skipped;
  endproperty
  a_imm: assert property (p_imm) else $error("equal compare did not skip");

  property p_ext0;
    exec && (w == OP_EXT0_FLAG) && !s_r.ictl1[EXT0_EN_BIT] && s_r.flags.ext0 && !req_set.ext0
      |=> !req_flags.ext0 && (s_r.seq == SEQ_SKIP);
  endproperty
  a_ext0: assert property (p_ext0) else $error("ext0 test did not skip and clear");

  property p_noop;
    exec && (w == OP_TMR1_TEST) && s_r.ictl1[TMR1_EN_BIT] && s_r.flags.t1
      |=> req_flags.t1 && (s_r.seq == SEQ_RUN);
  endproperty
  a_noop: assert property (p_noop) else $error("enabled timer1 test acted");

  property p_pin0;
    exec && (w == OP_EXT0_PIN)
      |=> (s_r.seq == SEQ_SKIP) == ($past(pin0_s) == $past(s_r.inctl1[POL_BIT]));
  endproperty
  a_pin0: assert property (p_pin0) else $error("ext0 pin test wrong");

  property p_pwr;
    exec && (w == OP_PWRDN_TEST) && pwrdn_flag && (req_set == '0)
      |=> (s_r.seq == SEQ_SKIP) && $stable(req_flags);
  endproperty
  a_pwr: assert property (p_pwr) else $error("power-down test did not skip");

  property p_skip;
    (s_r.seq == SEQ_SKIP) && instr.valid && (w != OP_IMM_CMP)
      |=> word_skipped && pc_inc ##1 !word_skipped || pc_inc;
  endproperty
  a_skip: assert property (p_skip) else $error("skipped word not dropped");

  property p_bank_clr;
    exec && (w == OP_BANK_CLR) |=> !table_bank_bit;
  endproperty
  a_bank_clr: assert property (p_bank_clr) else $error("bank clear missed");

  c_skip2: cover property ((s_r.seq == SEQ_SKIP) && instr.valid && (w == OP_IMM_CMP));
  c_clear_set: cover property (|(ft_clr & req_set));
  c_imm_skip: cover property ((s_r.seq == SEQ_IMM) ##1 (s_r.seq == SEQ_SKIP));
  c_apb_err: cover property (apb_rsp.pready && apb_rsp.pslverr);
endmodule

// file: tb/ssu_exec_tb.sv
// Self-checking bench for the set and skip execution unit
`timescale 1ns/1ns
module ssu_exec_tb;
  import ssu_pkg::*;
  logic         clk_sys, rstn, pwrdn_flag, ext0_pin, ext1_pin;
  ssu_apb_req_t apb_req;
  ssu_apb_rsp_t apb_rsp;
  ssu_instr_t   instr;
  ssu_req_t     req_set, req_flags;
  logic         pc_inc, word_skipped, table_bank_bit, tbl_page_vld, carry_set, port_c;
  logic [6:0]   tbl_page;
  logic [9:0]   port_d;
  int           err_total, n_compared, i, en, fl;
  logic [3:0]   a, n;
  // Reference model state
  int           m_skip;
  bit           m_imm, m_err;
  logic         m_bank, m_portc, e_pc, e_skp, e_cy, e_vld;
  logic [6:0]   m_flags, e_page;
  logic [9:0]   m_portd;
  logic [1:0]   m_var;
  logic [3:0]   m_ic1, m_ic2, m_in1, m_in2;
  logic [9:0]   fop [7] = '{OP_EXT0_FLAG, OP_EXT1_FLAG, OP_CONV_TEST, OP_SER_TEST,
                            OP_TMR1_TEST, OP_TMR2_TEST, OP_TMR3_TEST};
  int           fbit [7] = '{EXT0_EN_BIT, EXT1_EN_BIT, CONV_EN_BIT, SER_EN_BIT,
                             TMR1_EN_BIT, TMR2_EN_BIT, TMR3_EN_BIT};
  bit           freg [7] = '{0, 0, 1, 1, 0, 0, 1};

  ssu_exec ssu_exec_i (
    .clk_sys(clk_sys), .rstn(rstn), .apb_req(apb_req), .apb_rsp(apb_rsp), .instr(instr),
    .pwrdn_flag(pwrdn_flag), .req_set(req_set), .ext0_pin(ext0_pin), .ext1_pin(ext1_pin),
    .pc_inc(pc_inc), .word_skipped(word_skipped), .table_bank_bit(table_bank_bit),
    .tbl_page(tbl_page), .tbl_page_vld(tbl_page_vld), .carry_set(carry_set),
    .port_c(port_c), .port_d(port_d), .req_flags(req_flags)
  );

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %0h want %0h", $time, what, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  function automatic logic [31:0] stat();
    return {20'h0, m_err, m_flags, 1'b0, pwrdn_flag, m_portc, m_bank};
  endfunction

  // Drives one word, checks the previous word's results, then models this word
  task automatic step(input logic v, input logic [9:0] w, input logic [3:0] ac = 0,
                      input logic [3:0] mm = 0, input logic [3:0] yy = 0);
    logic [6:0] pg;
    @(posedge clk_sys);
    instr <= '{valid: v, word: w, acc: ac, mem: mm, y: yy};
    @(negedge clk_sys);
    chk(pc_inc, e_pc, "pc_inc");
    chk(word_skipped, e_skp, "skip");
    chk(carry_set, e_cy, "carry");
    chk(tbl_page_vld, e_vld, "page valid");
    if (e_vld)
      chk(tbl_page, e_page, "page");
    chk(table_bank_bit, m_bank, "bank");
    chk(port_c, m_portc, "port c");
    chk(port_d, m_portd, "port d");
    chk(req_flags, m_flags, "flags");
    {e_pc, e_skp, e_cy, e_vld} = {v, 3'b000};
    if (!v)
      return;
    if (m_skip > 0) begin
      e_skp = 1'b1;
      m_skip = m_skip - 1 + int'(w == OP_IMM_CMP);
    end else if (m_imm) begin
      m_imm = 0;
      m_skip = int'(ac == w[3:0]);
    end else begin
      case (w)
        OP_BANK_SET:   if (m_var != VAR_SMALL) m_bank = 1'b1;
        OP_BANK_CLR:   m_bank = 1'b0;
        OP_CARRY_SET:  e_cy = 1'b1;
        OP_PORTC_SET:  m_portc = 1'b1;
        OP_PORTD_SET:  if (yy <= PORTD_LAST) m_portd[yy] = 1'b1;
        OP_IMM_CMP:    m_imm = 1;
        OP_MEM_CMP:    m_skip = int'(ac == mm);
        OP_EXT0_PIN:   m_skip = int'(ext0_pin == m_in1[POL_BIT]);
        OP_EXT1_PIN:   m_skip = int'(ext1_pin == m_in2[POL_BIT]);
        OP_PWRDN_TEST: m_skip = int'(pwrdn_flag);
        default: begin
          for (int k = 0; k < 7; k++)
            if (w == fop[k] && !(freg[k] ? m_ic2[fbit[k]] : m_ic1[fbit[k]]) && m_flags[k]) begin
              m_skip = 1;
              m_flags[k] = 1'b0;
            end
          if (w[9:6] == TBL_REF_HI) begin
            pg = {m_bank, w[5:0]};
            {e_vld, e_page} = {1'b1, pg};
            if (pg > (m_var == VAR_SMALL ? LAST_SMALL : m_var == VAR_MID ? LAST_MID : LAST_FULL))
              m_err = 1;
          end
        end
      endcase
    end
  endtask

  // One APB transfer; waits for pready at a rising edge under a bound
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int c;
    @(posedge clk_sys);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: ad, pwdata: wd};
    @(posedge clk_sys);
    apb_req.penable <= 1'b1;
    c = 0;
    do begin
      @(posedge clk_sys);
      c++;
    end while (apb_rsp.pready !== 1'b1 && c < 16);
    if (c >= 16)
      chk(0, 1, "apb hang");
    rd = apb_rsp.prdata;
    er = apb_rsp.pslverr;
    apb_req <= '0;
    if (wr)
      case (ad)
        ADDR_CTRL:   m_var = wd[1:0];
        ADDR_ICTL1:  m_ic1 = wd[3:0];
        ADDR_ICTL2:  m_ic2 = wd[3:0];
        ADDR_INCTL1: m_in1 = wd[3:0];
        ADDR_INCTL2: m_in2 = wd[3:0];
        ADDR_STATUS: if (wd[ST_PAGE_ERR]) m_err = 0;
        default: ;
      endcase
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, ad, d, r, e);
  endtask

  task automatic rdc(input logic [7:0] ad, input logic [31:0] x, input logic xe = 1'b0);
    logic [31:0] r;
    logic        e;
    apb(1'b0, ad, 32'h0, r, e);
    chk(r, x, "read data");
    chk(e, xe, "slave error");
  endtask

  task automatic raise(input logic [6:0] mk);
    @(posedge clk_sys);
    req_set <= mk;
    @(posedge clk_sys);
    req_set <= '0;
    m_flags |= mk;
  endtask

  // Bound is far above the few hundred cycles the tests take
  initial begin
    #(50 * 20000);
    chk(0, 1, "watchdog");
    complete_run;
  end

  initial begin
    {err_total, n_compared, m_skip, m_imm, m_err} = '0;
    {m_bank, m_portc, e_pc, e_skp, e_cy, e_vld, m_flags, e_page, m_portd} = '0;
    {m_ic1, m_ic2, m_in1, m_in2} = '0;
    m_var = VAR_FULL;
    {rstn, pwrdn_flag, ext0_pin, ext1_pin, apb_req, instr, req_set} = '0;
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    void'($urandom(8));
    rdc(ADDR_CTRL, 32'(VAR_FULL));
    rdc(ADDR_ICTL1, 32'h0);
    rdc(ADDR_STATUS, stat());
    rdc(8'h1c, 32'h0, 1'b1);
    wr(ADDR_INCTL1, 32'h4);
    rdc(ADDR_INCTL1, 32'h4);
    wr(ADDR_INCTL1, 32'h0);
    $display("test registers done");
    step(1, OP_CARRY_SET);
    step(1, OP_PORTC_SET);
    for (int y = 0; y < 12; y++)
      step(1, OP_PORTD_SET, 4'h0, 4'h0, 4'(y));
    step(1, OP_BANK_SET);
    step(1, {TBL_REF_HI, 6'($urandom)});
    step(1, OP_BANK_CLR);
    step(1, {TBL_REF_HI, 6'h3f});
    step(0, 10'h0);
    rdc(ADDR_PORTD, 32'(m_portd));
    $display("test set instructions done");
    repeat (24) begin
      a = 4'($urandom);
      n = $urandom_range(1) ? a : 4'($urandom);
      if ($urandom_range(1)) begin
        step(1, OP_IMM_CMP, a);
        step(1, {6'h07, n}, a);
      end else
        step(1, OP_MEM_CMP, a, n);
      step(1, OP_IMM_CMP, a);
      step(1, {6'h07, a}, a);
      step(1, OP_CARRY_SET);
    end
    step(0, 10'h0);
    $display("test compares done");
    for (int k = 0; k < 28; k++) begin
      i = k % 7;
      en = k / 7 % 2;
      fl = k / 14;
      wr(freg[i] ? ADDR_ICTL2 : ADDR_ICTL1, 32'(en) << fbit[i]);
      if (fl != 0)
        raise(7'($urandom) | 7'(1 << i));
      step(1, fop[i]);
      step(1, OP_CARRY_SET);
      step(0, 10'h0);
    end
    rdc(ADDR_STATUS, stat());
    $display("test flag skips done");
    for (int k = 0; k < 8; k++) begin
      wr(k[2] ? ADDR_INCTL2 : ADDR_INCTL1, {29'h0, k[0], 2'h0});
      @(posedge clk_sys);
      {ext1_pin, ext0_pin, pwrdn_flag} <= {3{k[1]}};
      repeat (3) step(0, 10'h0);
      step(1, k[2] ? OP_EXT1_PIN : OP_EXT0_PIN);
      step(1, OP_CARRY_SET);
      step(1, OP_PWRDN_TEST);
      step(1, OP_CARRY_SET);
      step(0, 10'h0);
      rdc(ADDR_STATUS, stat());
    end
    $display("test pin skips done");
    // Small variant has no upper region; mid variant ends at page 95
    wr(ADDR_CTRL, 32'(VAR_SMALL));
    step(1, OP_BANK_SET);
    step(1, {TBL_REF_HI, 6'h3f});
    step(0, 10'h0);
    wr(ADDR_CTRL, 32'(VAR_MID));
    step(1, OP_BANK_SET);
    step(1, {TBL_REF_HI, 6'h1f});
    step(0, 10'h0);
    rdc(ADDR_STATUS, stat());
    step(1, {TBL_REF_HI, 6'h20});
    step(0, 10'h0);
    rdc(ADDR_STATUS, stat());
    wr(ADDR_STATUS, 32'h1 << ST_PAGE_ERR);
    rdc(ADDR_STATUS, stat());
    $display("test variants done");
    complete_run;
  end
endmodule
